// ---- dv/reg_host.sv ----
// Host model: single-byte register writes and reads on the strobe port.
// Assumes the block samples strobes on the rising edge of sys_clk.
`timescale 1ns/1ps
`default_nettype none
module reg_host (
	input  wire logic       sys_clk,
	input  wire logic [7:0] reg_rdata,
	output var logic  [7:0] reg_addr,
	output var logic  [7:0] reg_wdata,
	output var logic        reg_wr,
	output var logic        reg_rd
);
	initial begin
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		reg_wr = 1'h0;
		reg_rd = 1'h0;
	end
	// Released strobes go low; address and data lines carry the inverse of their last value
	task automatic idle();
		reg_wr = 1'h0;
		reg_rd = 1'h0;
		reg_addr = ~reg_addr;
		reg_wdata = ~reg_wdata;
	endtask
	task automatic write(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		#2;
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'h1;
		@(posedge sys_clk);
		#2;
		idle();
	endtask
	task automatic read(input logic [7:0] a, output logic [7:0] d);
		@(posedge sys_clk);
		#2;
		reg_addr = a;
		reg_rd = 1'h1;
		@(posedge sys_clk);
		#2;
		d = reg_rdata;
		idle();
	endtask
endmodule
`default_nettype wire

// ---- dv/testbench.sv ----
// Self-checking bench for the wake pin and watchdog configuration block.
// Assumes the host model and checker are compiled before this file.
`timescale 1ns/1ps
`default_nettype none
`include "wake_cfg_defs.svh"
module testbench;
	localparam int TICK = 4;
	logic       sys_clk, rst_b, reg_wr, reg_rd, wake_pin, rx_bus_in, rx_pin_out;
	logic       global_irq, bus_fault_irq, irq_out_n, wake_request, wd_error_event;
	logic       wd_tally_clear, wd_irq_clear, watchdog_irq_flag, supply_enable_out;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, rd_val;
	logic [1:0] watchdog_mode_field;
	logic [2:0] watchdog_scale_factor;
	logic [3:0] watchdog_error_tally;
	int         num_errors = 0;
	int         num_checks = 0;
	int         cycles = 0;
	wake_watchdog_config #(.MS_TICK_CYCLES(TICK)) uut (.*);
	reg_host host (.*);
	initial begin
		sys_clk = 1'h0;
		forever #12.5 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 20000) begin
			num_errors++;
			$display("[FAIL] %0t timeout", $time);
			give_verdict();
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	task automatic give_verdict();
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	task automatic cmp_reg(input logic [7:0] got, input logic [7:0] exp, input string w);
		num_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] %0t %s got %h exp %h", $time, w, got, exp);
		end
	endtask
	task automatic cmp_pin(input logic got, input logic exp, input string w);
		cmp_reg({7'h0, got}, {7'h0, exp}, w);
	endtask
	task automatic check_read(input logic [7:0] a, input logic [7:0] e, input string w);
		host.read(a, rd_val);
		cmp_reg(rd_val, e, w);
	endtask
	task automatic wait_cyc(input int n);
		repeat (n) @(posedge sys_clk);
		#2;
	endtask
	task automatic pulse(ref logic s);
		@(posedge sys_clk);
		#2;
		s = 1'h1;
		@(posedge sys_clk);
		#2;
		s = 1'h0;
	endtask
	task automatic t_regs();
		check_read(`REG_WAKE_INPUT_SETUP, 8'h04, "rst11");
		check_read(`REG_PIN_FUNCTION_SETUP, 8'h00, "rst12");
		check_read(`REG_WATCHDOG_SETUP_ONE, 8'h15, "rst13");
		host.write(8'h20, 8'hFF);
		check_read(8'h20, 8'h00, "unmapped");
		host.write(`REG_PIN_FUNCTION_SETUP, 8'hFF);
		check_read(`REG_PIN_FUNCTION_SETUP, 8'h9C, "rsvd");
		host.write(`REG_WAKE_INPUT_SETUP, 8'h3F);
		check_read(`REG_WAKE_INPUT_SETUP, 8'h0F, "stat wr");
		host.write(`REG_WAKE_INPUT_SETUP, 8'h04);
		for (int p = 0; p < 4; p++) begin
			host.write(`REG_WATCHDOG_SETUP_ONE, {p[1:0], p[1:0], 4'h5});
			wait_cyc(1);
			cmp_reg({6'h0, watchdog_mode_field}, {6'h0, p[1:0]}, "mode");
			cmp_reg({5'h0, watchdog_scale_factor}, 8'(p + 1), "scale");
		end
	endtask
	task automatic t_wake_edges();
		logic [1:0] er [3] = '{2'h1, 2'h1, 2'h0};
		logic [1:0] ef [3] = '{2'h2, 2'h0, 2'h2};
		logic       rx_a;
		host.write(`REG_PIN_FUNCTION_SETUP, 8'h18);
		for (int m = 0; m < 3; m++) begin
			host.write(`REG_WAKE_INPUT_SETUP, {m[1:0], 6'h04});
			wake_pin = 1'h1;
			wait_cyc(4);
			host.write(`REG_WAKE_INPUT_SETUP, {m[1:0], 6'h14});
			check_read(`REG_WAKE_INPUT_SETUP, {m[1:0], er[m], 4'h4}, "rise");
			cmp_pin(wake_request, er[m] != 2'h0, "wreq");
			cmp_pin(irq_out_n, er[m] == 2'h0, "irq wake");
			cmp_pin(rx_pin_out, er[m] == 2'h0, "rx low");
			host.write(`REG_WAKE_INPUT_SETUP, {m[1:0], 6'h04});
			wake_pin = 1'h0;
			wait_cyc(4);
			check_read(`REG_WAKE_INPUT_SETUP, {m[1:0], ef[m], 4'h4}, "fall");
		end
		host.write(`REG_WAKE_INPUT_SETUP, 8'h04);
		host.write(`REG_PIN_FUNCTION_SETUP, 8'h1C);
		wake_pin = 1'h1;
		wait_cyc(4);
		rx_a = rx_pin_out;
		wait_cyc(TICK);
		cmp_pin(rx_pin_out, ~rx_a, "rx toggle");
		wake_pin = 1'h0;
		wait_cyc(4);
		host.write(`REG_WAKE_INPUT_SETUP, 8'h04);
	endtask
	task automatic pulse_case(input logic pol, input int ms, input logic [1:0] e);
		host.write(`REG_PIN_FUNCTION_SETUP, {pol, 7'h00});
		wake_pin = pol;
		wait_cyc(4);
		host.write(`REG_WAKE_INPUT_SETUP, 8'hC4);
		wake_pin = ~pol;
		wait_cyc(ms * TICK);
		wake_pin = pol;
		wait_cyc(8);
		check_read(`REG_WAKE_INPUT_SETUP, {2'h3, e, 4'h4}, "pulse");
		host.write(`REG_WAKE_INPUT_SETUP, 8'h04);
	endtask
	task automatic t_wake_pulse();
		pulse_case(1'h0, 30, 2'h3);
		pulse_case(1'h0, 15, 2'h0);
		pulse_case(1'h1, 30, 2'h3);
		pulse_case(1'h0, 760, 2'h1);
		pulse_case(1'h1, 760, 2'h2);
	endtask
	task automatic t_irq_sel();
		for (int s = 0; s < 4; s++) begin
			host.write(`REG_PIN_FUNCTION_SETUP, {3'h0, s[1:0], 3'h0});
			global_irq = 1'h1;
			wait_cyc(2);
			cmp_pin(irq_out_n, s != 0, "irq glob");
			global_irq = 1'h0;
			bus_fault_irq = 1'h1;
			wait_cyc(2);
			cmp_pin(irq_out_n, s != 2, "irq bus");
			bus_fault_irq = 1'h0;
		end
	endtask
	task automatic t_watchdog();
		logic [3:0] cnt [4] = '{4'h1, 4'h5, 4'h9, 4'hF};
		host.write(`REG_PIN_FUNCTION_SETUP, 8'h08);
		for (int t = 1; t < 4; t++) begin
			pulse(wd_tally_clear);
			pulse(wd_irq_clear);
			host.write(`REG_WATCHDOG_SETUP_ONE, {4'h5, t[1:0], 2'h1});
			repeat (cnt[t] - 1) pulse(wd_error_event);
			cmp_pin(watchdog_irq_flag, 1'h0, "early");
			pulse(wd_error_event);
			cmp_pin(watchdog_irq_flag, 1'h1, "fire");
			cmp_reg({4'h0, watchdog_error_tally}, {4'h0, cnt[t]}, "tally");
			cmp_pin(supply_enable_out, 1'h1, "act01");
			wait_cyc(1);
			cmp_pin(irq_out_n, 1'h0, "irq wd");
		end
		repeat (3) pulse(wd_error_event);
		cmp_reg({4'h0, watchdog_error_tally}, 8'h0F, "sat");
		pulse(wd_irq_clear);
		host.write(`REG_WATCHDOG_SETUP_ONE, 8'h50);
		pulse(wd_error_event);
		cmp_pin(watchdog_irq_flag, 1'h1, "act00 flag");
		cmp_pin(supply_enable_out, 1'h0, "act00 off");
		wait_cyc(298 * TICK);
		cmp_pin(supply_enable_out, 1'h0, "off hold");
		wait_cyc(4 * TICK);
		cmp_pin(supply_enable_out, 1'h1, "off end");
		pulse(wd_irq_clear);
		host.write(`REG_WATCHDOG_SETUP_ONE, 8'h52);
		pulse(wd_error_event);
		cmp_pin(watchdog_irq_flag, 1'h0, "act rsvd");
		pulse(wd_tally_clear);
		host.write(`REG_WATCHDOG_SETUP_ONE, 8'h15);
		pulse(wd_error_event);
		cmp_reg({4'h0, watchdog_error_tally}, 8'h00, "wd off");
	endtask
	initial begin
		rst_b = 1'h0;
		{wake_pin, global_irq, bus_fault_irq} = 3'h0;
		{wd_error_event, wd_tally_clear, wd_irq_clear} = 3'h0;
		rx_bus_in = 1'h1;
		repeat (16) @(posedge sys_clk);
		#2;
		rst_b = 1'h1;
		t_regs();
		t_wake_edges();
		t_wake_pulse();
		t_irq_sel();
		t_watchdog();
		give_verdict();
	end
endmodule
bind wake_watchdog_config wake_watchdog_config_checker chk (.*);
`default_nettype wire

// ---- dv/wake_watchdog_config_checker.sv ----
// Port-level checks for the wake pin and watchdog configuration block.
// Assumes a bind from the bench; declares only the ports it watches.
`timescale 1ns/1ps
`default_nettype none
`include "wake_cfg_defs.svh"
module wake_watchdog_config_checker (
	input wire logic       sys_clk,
	input wire logic       rst_b,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic       reg_wr,
	input wire logic       reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic       global_irq,
	input wire logic       rx_pin_out,
	input wire logic       irq_out_n,
	input wire logic       wake_request,
	input wire logic       wd_error_event,
	input wire logic       wd_tally_clear,
	input wire logic [1:0] watchdog_mode_field,
	input wire logic [2:0] watchdog_scale_factor,
	input wire logic [3:0] watchdog_error_tally,
	input wire logic       watchdog_irq_flag,
	input wire logic       supply_enable_out
);
	logic [1:0] irq_sel_ff;
	logic       rx_beh_ff;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_b);
	// Shadow of the pin function selectors
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			irq_sel_ff <= 2'h0;
			rx_beh_ff  <= 1'h0;
		end else if (reg_wr && reg_addr == `REG_PIN_FUNCTION_SETUP) begin
			irq_sel_ff <= reg_wdata[4:3];
			rx_beh_ff  <= reg_wdata[2];
		end
	end
	chk_mode_follow: assert property (reg_wr && reg_addr == `REG_WATCHDOG_SETUP_ONE
		|=> watchdog_mode_field == $past(reg_wdata[7:6])) else $error("mode field");
	chk_scale_step: assert property (reg_wr && reg_addr == `REG_WATCHDOG_SETUP_ONE
		##1 !reg_wr |=> watchdog_scale_factor == $past(reg_wdata[5:4], 2) + 3'h1)
		else $error("scale factor");
	chk_tally_step: assert property (wd_error_event && watchdog_mode_field != 2'h0
		&& watchdog_error_tally != 4'hF
		|=> watchdog_error_tally == $past(watchdog_error_tally) + 4'h1) else $error("tally step");
	chk_tally_sat: assert property (wd_error_event && watchdog_error_tally == 4'hF
		&& watchdog_mode_field != 2'h0 |=> watchdog_error_tally == 4'hF) else $error("tally sat");
	chk_wd_off: assert property (wd_error_event && watchdog_mode_field == 2'h0
		&& !wd_tally_clear |=> $stable(watchdog_error_tally) && !$rose(watchdog_irq_flag))
		else $error("event in mode off");
	chk_supply_hold: assert property ($fell(supply_enable_out) |-> watchdog_irq_flag
		##1 !supply_enable_out [*8]) else $error("supply drop");
	chk_supply_cause: assert property ($fell(supply_enable_out)
		|-> $past(wd_error_event)) else $error("supply cause");
	chk_irq_global: assert property ($past(irq_sel_ff) == 2'h0
		|-> irq_out_n == !$past(global_irq)) else $error("irq global");
	chk_irq_wake: assert property ($past(irq_sel_ff) == 2'h3
		|-> irq_out_n == !wake_request) else $error("irq wake");
	chk_rx_low: assert property (!$past(rx_beh_ff) && wake_request
		|-> !rx_pin_out) else $error("rx low");
	chk_rd_unmapped: assert property (reg_rd && !(reg_addr inside {8'h11, 8'h12, 8'h13})
		|=> reg_rdata == 8'h00) else $error("unmapped read");
	cover property ($fell(supply_enable_out));
	cover property ($rose(wake_request));
	cover property (wd_error_event && watchdog_error_tally == 4'hF);
endmodule
`default_nettype wire

// ---- src/wake_cfg_defs.svh ----
// Offsets, field positions, reset values and timing counts for the
// wake pin and watchdog configuration block.
// Assumes a 40 MHz sys_clk and an 8-bit register access port.
`ifndef WAKE_CFG_DEFS_SVH
`define WAKE_CFG_DEFS_SVH

`define REG_WAKE_INPUT_SETUP    8'h11
`define REG_PIN_FUNCTION_SETUP  8'h12
`define REG_WATCHDOG_SETUP_ONE  8'h13

`define RST_WAKE_INPUT_SETUP    8'h04
`define RST_PIN_FUNCTION_SETUP  8'h00
`define RST_WATCHDOG_SETUP_ONE  8'h15
`define RDATA_UNMAPPED          8'h00

// wake_input_setup fields
`define F_WAKE_MODE_HI          7
`define F_WAKE_MODE_LO          6
`define F_WAKE_STAT_HI          5
`define F_WAKE_STAT_LO          4
`define F_WAKE_INVAL_HI         3
`define F_WAKE_INVAL_LO         2
`define F_WAKE_MAX_HI           1
`define F_WAKE_MAX_LO           0
// pin_function_setup fields
`define F_WAKE_POLARITY         7
`define F_IRQ_SEL_HI            4
`define F_IRQ_SEL_LO            3
`define F_RX_WAKE_BEH           2
`define PIN_FUNCTION_WR_MASK    8'h9C
// watchdog_setup_one fields
`define F_WD_MODE_HI            7
`define F_WD_MODE_LO            6
`define F_WD_SCALE_HI           5
`define F_WD_SCALE_LO           4
`define F_WD_THRESH_HI          3
`define F_WD_THRESH_LO          2
`define F_WATCHDOG_FAIL_ACTION_HI             1
`define F_WATCHDOG_FAIL_ACTION_LO             0

// Timing
`define CLK_PERIOD_NS           25
`define MS_TICK_NS              1000000
`define MS_TICK_CYCLES          (`MS_TICK_NS / `CLK_PERIOD_NS)
`define INHIBIT_OFF_MS          300
`define WAKE_INVALID_BASE_MS    5
`define WAKE_MIN_BASE_MS        10
`define WAKE_MAX0_MS            750
`define WAKE_MAX1_MS            1000
`define WAKE_MAX2_MS            1500
`define WAKE_MAX3_MS            2000
`define WD_TALLY_SAT            4'hF
`define WD_THRESH1_COUNT        4'h5
`define WD_THRESH2_COUNT        4'h9
`define WD_THRESH3_COUNT        4'hF

`endif

// ---- src/wake_cfg_pkg.sv ----
// Types shared by the wake pin and watchdog configuration block.
// Assumes nothing beyond a SystemVerilog compiler.
package wake_cfg_pkg;

	typedef enum logic [1:0] {
		WAKE_NONE    = 2'b00,
		WAKE_RISING  = 2'b01,
		WAKE_FALLING = 2'b10,
		WAKE_PULSE   = 2'b11
	} wake_code_e;

	typedef enum logic [1:0] {
		WD_OFF     = 2'b00,
		WD_TIMEOUT = 2'b01,
		WD_WINDOW  = 2'b10,
		WD_QA      = 2'b11
	} wd_mode_e;

	typedef enum logic [1:0] {
		IRQ_GLOBAL   = 2'b00,
		IRQ_WD_FAIL  = 2'b01,
		IRQ_BUSFAULT = 2'b10,
		IRQ_WAKE_REQ = 2'b11
	} irq_sel_e;

	typedef enum logic {
		DET_IDLE   = 1'b0,
		DET_TIMING = 1'b1
	} det_state_e;

endpackage

// ---- src/wake_pin_detector.sv ----
// Classifies activity on the wake pin into edge, pulse or filtered events.
// Assumes wake_pin is synchronous to sys_clk and ms_tick pulses once a ms.
`timescale 1ns/1ps
`default_nettype none
`include "wake_cfg_defs.svh"

module wake_pin_detector (
	input  wire logic       sys_clk,
	input  wire logic       rst_b,
	input  wire logic       ms_tick,
	input  wire logic       wake_pin,
	input  wire logic [1:0] wake_mode,
	input  wire logic       wake_polarity,
	input  wire logic [1:0] invalid_sel,
	input  wire logic [1:0] max_sel,
	output logic            event_valid_ff,
	output logic [1:0]      event_code_ff
);

	logic                      pin_q_ff;
	logic [11:0]               width_ff;
	wake_cfg_pkg::det_state_e  state_ff;
	logic                      rise;
	logic                      fall;
	logic                      lead;
	logic                      trail;
	logic [11:0]               lim_invalid;
	logic [11:0]               lim_min;
	logic [11:0]               lim_max;
	logic                      pulse_mode;

	assign rise        = wake_pin & ~pin_q_ff;
	assign fall        = ~wake_pin & pin_q_ff;
	assign lead        = wake_polarity ? fall : rise;  // RULE7
	assign trail       = wake_polarity ? rise : fall;  // RULE7
	assign pulse_mode  = (wake_mode == wake_cfg_pkg::WAKE_PULSE);
	assign lim_invalid = 12'(`WAKE_INVALID_BASE_MS) << invalid_sel;  // RULE5
	assign lim_min     = 12'(`WAKE_MIN_BASE_MS) << invalid_sel;  // RULE5

	always_comb begin
		unique case (max_sel)  // RULE6
			2'b00: lim_max = 12'(`WAKE_MAX0_MS);
			2'b01: lim_max = 12'(`WAKE_MAX1_MS);
			2'b10: lim_max = 12'(`WAKE_MAX2_MS);
			2'b11: lim_max = 12'(`WAKE_MAX3_MS);
		endcase
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			pin_q_ff <= 1'b0;
		end else begin
			pin_q_ff <= wake_pin;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			state_ff <= wake_cfg_pkg::DET_IDLE;
			width_ff <= 12'h000;
		end else if (!pulse_mode) begin
			state_ff <= wake_cfg_pkg::DET_IDLE;
			width_ff <= 12'h000;
		end else begin
			unique case (state_ff)
				wake_cfg_pkg::DET_IDLE: begin
					width_ff <= 12'h000;
					if (lead) begin
						state_ff <= wake_cfg_pkg::DET_TIMING;
					end
				end
				wake_cfg_pkg::DET_TIMING: begin
					if (trail || width_ff > lim_max) begin
						state_ff <= wake_cfg_pkg::DET_IDLE;
					end else if (ms_tick) begin
						width_ff <= width_ff + 12'h001;
					end
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			event_valid_ff <= 1'b0;
			event_code_ff  <= wake_cfg_pkg::WAKE_NONE;
		end else begin
			event_valid_ff <= 1'b0;
			if (!pulse_mode) begin
				if (rise && wake_mode != wake_cfg_pkg::WAKE_FALLING) begin  // RULE1
					event_valid_ff <= 1'b1;
					event_code_ff  <= wake_cfg_pkg::WAKE_RISING;  // RULE2
				end else if (fall && wake_mode != wake_cfg_pkg::WAKE_RISING) begin  // RULE1
					event_valid_ff <= 1'b1;
					event_code_ff  <= wake_cfg_pkg::WAKE_FALLING;  // RULE2
				end
			end else if (state_ff == wake_cfg_pkg::DET_TIMING) begin
				if (trail) begin
					// Width must clear the invalid limit and the minimum
					if (width_ff > lim_invalid && width_ff >= lim_min
						&& width_ff <= lim_max) begin  // RULE15
						event_valid_ff <= 1'b1;
						event_code_ff  <= wake_cfg_pkg::WAKE_PULSE;  // RULE2
					end
				end else if (width_ff > lim_max) begin
					// Level held past the maximum counts as a filtered edge
					event_valid_ff <= 1'b1;
					event_code_ff  <= wake_polarity ? wake_cfg_pkg::WAKE_FALLING
						: wake_cfg_pkg::WAKE_RISING;  // RULE4
				end
			end
		end
	end

endmodule
`default_nettype wire

// ---- src/wake_watchdog_config.sv ----
// Wake pin and watchdog configuration registers with their pin logic.
// Assumes an SPI front end that presents decoded register reads and writes
// as one-cycle strobes synchronous to sys_clk.
//
// How it works
// RULE1: The wake mode field picks either edge, rising, falling or pulse detection.
// RULE2: A detected wake event is recorded as 01 rising, 10 falling or 11 pulse.
// RULE3: The wake status holds until the host writes 00 to it, and a new event may set it again.
// RULE4: In filtered detection the event is reported as rising or falling per the polarity bit.
// RULE5: Pulses at or below 5/10/20/40 ms are invalid and the minimum width is 10/20/40/80 ms.
// RULE6: A pulse is valid only if no longer than 750/1000/1500/2000 ms.
// RULE7: Polarity 0 expects low-high-low pulses and rising filtered edges, 1 the opposite.
// RULE8: The interrupt pin shows global, watchdog fail, bus fault or wake request per its selector.
// RULE9: On a wake event the receive pin is held low or toggled per its behaviour bit.
// RULE10: The watchdog mode selects disabled, timeout, window or question-and-answer.
// RULE11: The watchdog scale selector gives a factor of 1 to 4.
// RULE12: The watchdog output fires on every event or on the 5th, 9th or 15th error.
// RULE13: Action 00 drops the supply enable for 300 ms and sets the watchdog flag, 01 only the flag.
// RULE14: The watchdog error tally counts errors and saturates at fifteen.
// RULE15: A pulse above the invalid limit, at or above the minimum and within the maximum is valid.
// RULE16: Reserved bits read zero and ignore writes, and reserved selector codes do nothing.
`timescale 1ns/1ps
`default_nettype none
`include "wake_cfg_defs.svh"

module wake_watchdog_config #(
	parameter int MS_TICK_CYCLES = `MS_TICK_CYCLES
) (
	input  wire logic       sys_clk,
	input  wire logic       rst_b,
	input  wire logic [7:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	output logic [7:0]      reg_rdata,
	input  wire logic       wake_pin,
	input  wire logic       rx_bus_in,
	output logic            rx_pin_out,
	input  wire logic       global_irq,
	input  wire logic       bus_fault_irq,
	output logic            irq_out_n,
	output logic            wake_request,
	input  wire logic       wd_error_event,
	input  wire logic       wd_tally_clear,
	input  wire logic       wd_irq_clear,
	output logic [1:0]      watchdog_mode_field,
	output logic [2:0]      watchdog_scale_factor,
	output logic [3:0]      watchdog_error_tally,
	output logic            watchdog_irq_flag,
	output logic            supply_enable_out
);

	////////////////////////////////////////////////////////////////////////
	// Millisecond tick

	logic [15:0] tick_cnt_ff;
	logic        ms_tick_ff;

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			tick_cnt_ff <= 16'h0000;
			ms_tick_ff  <= 1'b0;
		end else if (tick_cnt_ff == 16'(MS_TICK_CYCLES - 1)) begin
			tick_cnt_ff <= 16'h0000;
			ms_tick_ff  <= 1'b1;
		end else begin
			tick_cnt_ff <= tick_cnt_ff + 16'h0001;
			ms_tick_ff  <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Configuration registers

	logic [1:0] wake_mode_ff;
	logic [1:0] wake_stat_ff;
	logic [1:0] wake_inval_ff;
	logic [1:0] wake_max_ff;
	logic [7:0] pin_func_ff;
	logic [7:0] wd_setup_ff;
	logic       wr_wake;
	logic       wr_pin;
	logic       wr_wd;

	// Named copies of the reset bytes so that fields can be sliced from them
	localparam logic [7:0] WAKE_RST = `RST_WAKE_INPUT_SETUP;
	localparam logic [7:0] WD_RST   = `RST_WATCHDOG_SETUP_ONE;

	assign wr_wake = reg_wr && (reg_addr == `REG_WAKE_INPUT_SETUP);
	assign wr_pin  = reg_wr && (reg_addr == `REG_PIN_FUNCTION_SETUP);
	assign wr_wd   = reg_wr && (reg_addr == `REG_WATCHDOG_SETUP_ONE);

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			wake_mode_ff  <= WAKE_RST[`F_WAKE_MODE_HI:`F_WAKE_MODE_LO];
			wake_inval_ff <= WAKE_RST[`F_WAKE_INVAL_HI:`F_WAKE_INVAL_LO];
			wake_max_ff   <= WAKE_RST[`F_WAKE_MAX_HI:`F_WAKE_MAX_LO];
		end else if (wr_wake) begin
			wake_mode_ff  <= reg_wdata[`F_WAKE_MODE_HI:`F_WAKE_MODE_LO];  // RULE1
			wake_inval_ff <= reg_wdata[`F_WAKE_INVAL_HI:`F_WAKE_INVAL_LO];
			wake_max_ff   <= reg_wdata[`F_WAKE_MAX_HI:`F_WAKE_MAX_LO];
		end
	end

	// Reserved bits are never stored
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			pin_func_ff <= `RST_PIN_FUNCTION_SETUP;
		end else if (wr_pin) begin
			pin_func_ff <= reg_wdata & `PIN_FUNCTION_WR_MASK;  // RULE16
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			wd_setup_ff <= `RST_WATCHDOG_SETUP_ONE;
		end else if (wr_wd) begin
			wd_setup_ff <= reg_wdata;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Wake detection and status

	logic       det_valid;
	logic [1:0] det_code;
	logic       stat_clear;

	wake_pin_detector u_wake_det (
		.sys_clk        (sys_clk),
		.rst_b          (rst_b),
		.ms_tick        (ms_tick_ff),
		.wake_pin       (wake_pin),
		.wake_mode      (wake_mode_ff),
		.wake_polarity  (pin_func_ff[`F_WAKE_POLARITY]),
		.invalid_sel    (wake_inval_ff),
		.max_sel        (wake_max_ff),
		.event_valid_ff (det_valid),
		.event_code_ff  (det_code)
	);

	// Only a write of 00 clears the status; other values leave it alone
	assign stat_clear = wr_wake && (reg_wdata[`F_WAKE_STAT_HI:`F_WAKE_STAT_LO] == 2'b00);

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			wake_stat_ff <= WAKE_RST[`F_WAKE_STAT_HI:`F_WAKE_STAT_LO];
		end else if (det_valid) begin
			wake_stat_ff <= det_code;  // RULE2
		end else if (stat_clear) begin
			wake_stat_ff <= 2'b00;  // RULE3
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Receive pin wake signalling

	logic rx_toggle_ff;
	logic wake_pending;

	assign wake_pending = (wake_stat_ff != 2'b00);

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			rx_toggle_ff <= 1'b1;
		end else if (!wake_pending) begin
			rx_toggle_ff <= 1'b1;
		end else if (ms_tick_ff) begin
			rx_toggle_ff <= ~rx_toggle_ff;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			rx_pin_out <= 1'b1;
		end else if (wake_pending) begin
			rx_pin_out <= pin_func_ff[`F_RX_WAKE_BEH] ? rx_toggle_ff : 1'b0;  // RULE9
		end else begin
			rx_pin_out <= rx_bus_in;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Watchdog failure handling

	logic [3:0] tally;
	logic       wd_irq;
	logic       supply_en;

	watchdog_fail_handler u_wd_fail (
		.sys_clk          (sys_clk),
		.rst_b            (rst_b),
		.ms_tick          (ms_tick_ff),
		.wd_mode          (wd_setup_ff[`F_WD_MODE_HI:`F_WD_MODE_LO]),
		.threshold_sel    (wd_setup_ff[`F_WD_THRESH_HI:`F_WD_THRESH_LO]),
		.action_sel       (wd_setup_ff[`F_WATCHDOG_FAIL_ACTION_HI:`F_WATCHDOG_FAIL_ACTION_LO]),
		.wd_error_event   (wd_error_event),
		.wd_tally_clear   (wd_tally_clear),
		.wd_irq_clear     (wd_irq_clear),
		.tally_ff         (tally),
		.wd_irq_ff        (wd_irq),
		.supply_enable_ff (supply_en)
	);

	assign watchdog_error_tally = tally;
	assign watchdog_irq_flag    = wd_irq;
	assign supply_enable_out    = supply_en;
	assign watchdog_mode_field  = wd_setup_ff[`F_WD_MODE_HI:`F_WD_MODE_LO];  // RULE10

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			watchdog_scale_factor <= 3'(WD_RST[`F_WD_SCALE_HI:`F_WD_SCALE_LO]) + 3'h1;
		end else begin
			watchdog_scale_factor <= 3'(wd_setup_ff[`F_WD_SCALE_HI:`F_WD_SCALE_LO]) + 3'h1;  // RULE11
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Interrupt pin function

	logic irq_level;

	always_comb begin
		unique case (pin_func_ff[`F_IRQ_SEL_HI:`F_IRQ_SEL_LO])  // RULE8
			wake_cfg_pkg::IRQ_GLOBAL:   irq_level = global_irq;
			wake_cfg_pkg::IRQ_WD_FAIL:  irq_level = wd_irq;
			wake_cfg_pkg::IRQ_BUSFAULT: irq_level = bus_fault_irq;
			wake_cfg_pkg::IRQ_WAKE_REQ: irq_level = wake_pending;
		endcase
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			irq_out_n    <= 1'b1;
			wake_request <= 1'b0;
		end else begin
			irq_out_n    <= ~irq_level;
			wake_request <= wake_pending;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read back

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			reg_rdata <= `RDATA_UNMAPPED;
		end else if (reg_rd) begin
			unique case (reg_addr)
				`REG_WAKE_INPUT_SETUP:
					reg_rdata <= {wake_mode_ff, wake_stat_ff, wake_inval_ff, wake_max_ff};
				`REG_PIN_FUNCTION_SETUP:
					reg_rdata <= pin_func_ff;  // RULE16
				`REG_WATCHDOG_SETUP_ONE:
					reg_rdata <= wd_setup_ff;
				default:
					reg_rdata <= `RDATA_UNMAPPED;
			endcase
		end
	end

endmodule
`default_nettype wire

// ---- src/watchdog_fail_handler.sv ----
// Counts watchdog errors against a threshold and runs the failure action.
// Assumes wd_error_event is a one-cycle pulse from the watchdog timer.
`timescale 1ns/1ps
`default_nettype none
`include "wake_cfg_defs.svh"

module watchdog_fail_handler #(
	parameter int INHIBIT_MS = `INHIBIT_OFF_MS
) (
	input  wire logic       sys_clk,
	input  wire logic       rst_b,
	input  wire logic       ms_tick,
	input  wire logic [1:0] wd_mode,
	input  wire logic [1:0] threshold_sel,
	input  wire logic [1:0] action_sel,
	input  wire logic       wd_error_event,
	input  wire logic       wd_tally_clear,
	input  wire logic       wd_irq_clear,
	output logic [3:0]      tally_ff,
	output logic            wd_irq_ff,
	output logic            supply_enable_ff
);

	logic [3:0] nxt_tally;
	logic       hit;
	logic       fire;
	logic [8:0] off_cnt_ff;

	assign nxt_tally = (tally_ff == `WD_TALLY_SAT) ? tally_ff : tally_ff + 4'h1;  // RULE14

	always_comb begin
		unique case (threshold_sel)  // RULE12
			2'b00: hit = 1'b1;
			2'b01: hit = (nxt_tally == `WD_THRESH1_COUNT) && (tally_ff != nxt_tally);
			2'b10: hit = (nxt_tally == `WD_THRESH2_COUNT) && (tally_ff != nxt_tally);
			2'b11: hit = (nxt_tally == `WD_THRESH3_COUNT) && (tally_ff != nxt_tally);
		endcase
	end

	// Disabled watchdog ignores error events
	assign fire = wd_error_event && (wd_mode != wake_cfg_pkg::WD_OFF) && hit;  // RULE10

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			tally_ff <= 4'h0;
		end else if (wd_error_event && wd_mode != wake_cfg_pkg::WD_OFF) begin
			tally_ff <= nxt_tally;  // RULE14
		end else if (wd_tally_clear) begin
			tally_ff <= 4'h0;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			wd_irq_ff <= 1'b0;
		end else if (fire && (action_sel == 2'b00 || action_sel == 2'b01)) begin
			wd_irq_ff <= 1'b1;  // RULE13
		end else if (wd_irq_clear) begin
			wd_irq_ff <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			off_cnt_ff       <= 9'h000;
			supply_enable_ff <= 1'b1;
		end else if (fire && action_sel == 2'b00) begin
			off_cnt_ff       <= 9'(INHIBIT_MS);  // RULE13
			supply_enable_ff <= 1'b0;
		end else if (off_cnt_ff != 9'h000) begin
			if (ms_tick) begin
				off_cnt_ff <= off_cnt_ff - 9'h001;
			end
		end else begin
			supply_enable_ff <= 1'b1;
		end
	end

endmodule
`default_nettype wire
